//--- inc/emb_params.svh
// Constants for the external program memory bus pin controller.
// Assumes inclusion by the design file only.
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
// Register byte addresses on the control bus
`define EMB_ADDR_CTRL    4'h0
`define EMB_ADDR_STATUS  4'h4
`define EMB_ADDR_HOLD    4'h8
// Control register fields
`define EMB_DIS_BIT      7
`define EMB_WAIT_HI      5
`define EMB_WAIT_LO      4
`define EMB_WM_HI        1
`define EMB_WM_LO        0
`define EMB_CTRL_RST     8'h00
`define EMB_CTRL_MASK    8'hb3
// Write mode codes
`define EMB_WM_BYTEWR    2'h0
`define EMB_WM_BYTESEL   2'h1
// Last phase of the four-phase instruction cycle
`define EMB_QCOUNT       2'h3
// AXI responses
`define EMB_RESP_OKAY    2'h0
`define EMB_RESP_SLVERR  2'h2
`endif

//--- inc/emb_pkg.sv
// Types for the external program memory bus pin controller.
// Assumes emb_params.svh holds the numeric constants.
package emb_pkg;
  // Program memory mode strap
  typedef enum logic { EMB_MODE_ONCHIP, EMB_MODE_EXTENDED } emb_mode_type;
  // Address width strap
  typedef enum logic [1:0] { EMB_AW_12, EMB_AW_16, EMB_AW_20 } emb_aw_type;
  // Core request toward the bus
  typedef struct packed {
    logic        fetch;     // External fetch this cycle
    logic        tblRead;   // External table read
    logic        tblWrite;  // External table write
    logic [19:0] addr;      // Table pointer or program counter
    logic [7:0]  tableLatch;
  } emb_req_type;
  // Bus pins toward the memory
  typedef struct packed {
    logic [15:0] adOut;
    logic [15:0] adOe;
    logic [3:0]  aHigh;
    logic        aHighOe;
    logic        chipSel_n;
    logic        readStb_n;
    logic        wrStbHigh_n;
    logic        wrStbLow_n;
    logic        upperByteSel_n;
    logic        lowerByteSel_n;
    logic        addrLatch;
    logic        byteAddrLsb;
  } emb_pins_type;
endpackage : emb_pkg

//--- verification/emb_bus_ctrl_assertions.sv
// Checker on the bus pin controller ports.
// Assumes pins are registered, one clock behind their cause.
`timescale 1ns/100ps
module emb_bus_chk
(
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire logic                  clkEn,
  // Straps and power state
  input wire emb_pkg::emb_mode_type memMode,
  input wire emb_pkg::emb_aw_type   addrWidth,
  input wire logic                  sleepIdle,
  // Memory side
  input wire emb_pkg::emb_pins_type busPins,
  input wire logic                  busOwnsPins
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // Sleep keeps selects high; two cycles cover the pin lag
  AST_SLEEP_SEL: assert property (sleepIdle [*2] |-> busPins.chipSel_n
    && busPins.upperByteSel_n && busPins.lowerByteSel_n) else $error("select low in sleep");
  AST_SLEEP_FREEZE: assert property (sleepIdle [*3] |-> $stable(busPins.adOut)
    && $stable(busPins.adOe)) else $error("bus moved in sleep");
  AST_ONCHIP: assert property (memMode == emb_pkg::EMB_MODE_ONCHIP |-> !busOwnsPins
    && busPins.adOe == 16'h0 && busPins.readStb_n) else $error("bus active on chip");
  // Memory drives the lines while it is read
  AST_READ_RELEASE: assert property (!busPins.readStb_n |-> busPins.adOe == 16'h0
    && !busPins.chipSel_n) else $error("read without release");
  AST_STB_EXCL: assert property (!busPins.readStb_n |-> busPins.wrStbHigh_n
    && busPins.wrStbLow_n) else $error("read and write together");
  AST_ALE_PULSE: assert property ($rose(busPins.addrLatch) && clkEn && !sleepIdle
    |=> !busPins.addrLatch) else $error("latch pulse too long");
  AST_ALE_QUIET: assert property (busPins.addrLatch |-> busPins.readStb_n
    && busPins.wrStbHigh_n && busPins.wrStbLow_n) else $error("strobe in latch phase");
  AST_AW16: assert property (addrWidth == emb_pkg::EMB_AW_16 |-> !busPins.aHighOe)
    else $error("upper address driven");
  AST_DRIVE_OWNED: assert property (busPins.adOe != 16'h0 |-> busOwnsPins
    || $past(busOwnsPins)) else $error("drive without ownership");
endmodule : emb_bus_chk

bind emb_bus_ctrl emb_bus_chk u_chk (.ref_clk, .reset, .clkEn, .memMode, .addrWidth,
  .sleepIdle, .busPins, .busOwnsPins);

//--- verification/emb_bus_ctrl_bench.sv
// Self-checking bench for the bus pin controller.
// Assumes emb_mem_model stands on the pins; AXI master in tasks.
`timescale 1ns/100ps
module emb_bus_ctrl_bench;
  logic ref_clk = 1'b0, reset = 1'b1, clkEn = 1'b1, dataWidth16 = 1'b1, sleepIdle = 1'b0;
  emb_pkg::emb_mode_type memMode   = emb_pkg::EMB_MODE_EXTENDED;
  emb_pkg::emb_aw_type   addrWidth = emb_pkg::EMB_AW_20;
  emb_pkg::emb_req_type  coreReq   = '0;
  emb_pkg::emb_pins_type busPins;
  logic execInternal = 1'b1, coreStall, fetchValid, busOwnsPins;
  logic [15:0] fetchData, adIn, lastF;
  logic [20:0] wrLog;
  logic [7:0]  wrCnt, hold;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int fails = 0, n_compared = 0, cyc = 0, nF = 0, seed = 35420, i, n, ws[4];
  logic o;
  logic [1:0]  ph = 2'h0;
  emb_bus_ctrl DUT (.ref_clk, .reset, .clkEn, .memMode, .addrWidth, .dataWidth16, .sleepIdle,
    .coreReq, .execInternal, .coreStall, .fetchData, .fetchValid, .adIn, .busPins,
    .busOwnsPins, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  emb_mem_model u_mem (.ref_clk, .dataWidth16, .busPins, .adIn, .wrLog_ff(wrLog),
    .wrCnt_ff(wrCnt));
  always #5 ref_clk = ~ref_clk;
  // Fetched words and the run limit
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    // Phase mirror so core requests start on a cycle boundary
    if (reset) ph <= 2'h0;
    else if (clkEn && !sleepIdle && !(ph == 2'h3 && coreStall === 1'b1)) ph <= ph + 2'h1;
    if (fetchValid === 1'b1) lastF <= fetchData;
    if (fetchValid === 1'b1) nF <= nF + 1;
    if (cyc == 20000) fails++;
    if (cyc == 20000) test_done();
  end
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : mb
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) fails++;
    if (g !== e) $display("[FAIL] %0t got %h want %h", $time, g, e);
  endtask : chk
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task rst(input emb_pkg::emb_mode_type m, input logic w, input emb_pkg::emb_aw_type a);
    reset <= 1'b1;
    memMode <= m;
    dataWidth16 <= w;
    addrWidth <= a;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
  endtask : rst
  task axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, r);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : axiWr
  task axiRd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    chk({s_axi_rresp, s_axi_rdata}, {r, d});
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axiRd
  // Request held until the stall drops; notes whether the bus owned the pins
  task core(input logic [2:0] op, input logic [19:0] a, input logic [7:0] t);
    @(posedge ref_clk);
    while (ph !== 2'h3) @(posedge ref_clk);  // Next edge opens phase 0
    coreReq <= {op, a, t};
    n = 0;
    o = 1'b0;
    do
    begin
      @(posedge ref_clk);
      n++;
      o = o | busOwnsPins;
    end
    while (coreStall !== 1'b0);
    coreReq <= '0;
    repeat (3) @(posedge ref_clk);  // 8-bit word completes one clock later
  endtask : core
  task fetch;
    logic [19:0] a;
    a = 20'($random(seed)) & 20'hffffe;
    core(3'b100, a, 8'h0);
    chk(lastF, {mb({a[15:1], 1'b1}), mb({a[15:1], 1'b0})});
  endtask : fetch
  task tw(input logic [1:0] wm, input logic b);
    logic [7:0]  t, c;
    logic [20:0] e, m;
    logic        hit;
    t = 8'($random(seed));
    c = wrCnt;
    hit = !(dataWidth16 && wm[1] && !b);
    m = 21'h1fffff;
    axiWr(4'h0, {24'h0, 4'h3, 2'b00, wm}, 2'h0);
    core(3'b001, {19'h0, b}, t);
    if (!dataWidth16) m = 21'h19ffff;
    if (!dataWidth16) e = {4'b0100, b, t, t};
    else if (wm == 2'h0) m = 21'h18ffff;
    if (dataWidth16 && wm == 2'h0) e = {!b, b, 3'b000, t, t};
    if (dataWidth16 && wm == 2'h1) e = {2'b01, !b, b, b, t, t};
    if (dataWidth16 && wm[1]) e = {5'b01001, t, hold};
    chk(wrCnt - c, {7'h0, hit});
    if (hit) chk(wrLog & m, e & m);
    if (!hit) hold = t;
    if (!hit) axiRd(4'h8, {24'h0, t}, 2'h0);
  endtask : tw
  initial
  begin
    rst(emb_pkg::EMB_MODE_EXTENDED, 1'b1, emb_pkg::EMB_AW_20);
    axiRd(4'h0, 32'h0, 2'h0);
    axiRd(4'hc, 32'h0, 2'h2);
    axiWr(4'hc, 32'h0, 2'h2);
    chk(busOwnsPins, 1'b1);
    chk({busPins[7:0], busPins.aHighOe, busPins.adOe}, {6'h3f, 3'h0, 16'h0});
    i = $random(seed);
    axiWr(4'h0, i, 2'h0);
    axiRd(4'h0, i & 32'hb3, 2'h0);
    axiWr(4'h0, 32'h0, 2'h0);
    execInternal <= 1'b0;
    repeat (6) fetch();
    execInternal <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      axiWr(4'h0, 32'(i << 4), 2'h0);
      core(3'b010, 20'h00100, 8'h0);
      ws[i] = n;
    end
    for (i = 0; i < 3; i++) chk(ws[i] - ws[3], (3 - i) * 4);
    for (i = 0; i < 8; i++) tw(i[2:1], i[0]);
    axiWr(4'h0, 32'h80, 2'h0);
    repeat (8) @(posedge ref_clk);
    chk(busOwnsPins, 1'b0);
    core(3'b010, 20'h00200, 8'h0);
    chk(o, 1'b1);
    repeat (8) @(posedge ref_clk);
    chk(busOwnsPins, 1'b0);
    axiWr(4'h0, 32'h0, 2'h0);
    execInternal <= 1'b0;
    repeat (8) @(posedge ref_clk);
    axiWr(4'h0, 32'h80, 2'h0);
    repeat (8) @(posedge ref_clk);
    chk(busOwnsPins, 1'b1);
    execInternal <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(busOwnsPins, 1'b0);
    sleepIdle <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({busPins.chipSel_n, busPins.upperByteSel_n, busPins.lowerByteSel_n}, 3'h7);
    sleepIdle <= 1'b0;
    // Clock enable low must hold the phase counter still
    clkEn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    clkEn <= 1'b1;
    axiRd(4'h4, {30'h0, ph}, 2'h0);
    rst(emb_pkg::EMB_MODE_EXTENDED, 1'b0, emb_pkg::EMB_AW_16);
    execInternal <= 1'b0;
    repeat (4) fetch();
    tw(2'h0, 1'b0);
    tw(2'h0, 1'b1);
    rst(emb_pkg::EMB_MODE_ONCHIP, 1'b1, emb_pkg::EMB_AW_20);
    axiWr(4'h0, 32'h80, 2'h0);
    axiRd(4'h0, 32'h0, 2'h0);
    chk(busOwnsPins, 1'b0);
    test_done();
  end
endmodule : emb_bus_ctrl_bench

//--- verification/emb_mem_model.sv
// External memory on the bus pins: answers reads, logs writes.
// Assumes the bench reads the log a few clocks after each write.
`timescale 1ns/100ps
module emb_mem_model
(
  // Clock and wiring
  input  wire logic                  ref_clk,
  input  wire logic                  dataWidth16,
  // Bus pins
  input  wire emb_pkg::emb_pins_type busPins,
  output logic [15:0]                adIn,
  // Write log {high_n,low_n,upper_n,lower_n,byte,data}
  output logic [20:0]                wrLog_ff = 21'h0,
  output logic [7:0]                 wrCnt_ff = 8'h0
);
  logic [15:0] lat_ff  = 16'h0;
  logic [15:0] last_ff = 16'h0;
  logic        stbD_ff = 1'b0;
  logic        stb;
  function automatic logic [7:0] memByte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : memByte
  assign stb = !busPins.wrStbHigh_n || !busPins.wrStbLow_n;
  // Latch address, remember reads, log writes
  always_ff @(posedge ref_clk)
  begin
    if (busPins.addrLatch) lat_ff <= busPins.adOut;
    if (!busPins.readStb_n) last_ff <= adIn;
    if (stb) wrLog_ff <= {busPins.wrStbHigh_n, busPins.wrStbLow_n,
      busPins.upperByteSel_n, busPins.lowerByteSel_n, busPins.byteAddrLsb, busPins.adOut};
    if (stb && !stbD_ff) wrCnt_ff <= wrCnt_ff + 8'h1;
    stbD_ff <= stb;
  end
  // Released lines show the inverse, so stale data never looks right
  always_comb
  begin
    if (busPins.readStb_n) adIn = ~last_ff;
    else if (dataWidth16) adIn = {memByte({lat_ff[14:0], 1'b1}), memByte({lat_ff[14:0], 1'b0})};
    else adIn = {2{memByte({lat_ff[15:1], busPins.byteAddrLsb})}};
  end
endmodule : emb_mem_model

//--- verilog/emb_bus_ctrl.sv
// External program memory bus pin controller with AXI4-Lite registers.
// Assumes the core issues one external access per instruction cycle.
//
// Function
// R1: On-chip mode: bus idle, ports, control locked
// R2: Extended external access gives pins to bus
// R3: Internal-only: disable bit picks bus or port
// R4: External access overrides disable bit
// R5: Disable set externally waits for internal branch
// R6: Idle bus: tristate data, strobes high
// R7: Only configured address width pins are taken
// R8: Bus beats every other peripheral on pins
// R9: 16-bit reads: latch pulse then read strobe
// R10: Chip select low on access, high asleep
// R11: Byte write: latch both halves, LSb strobe
// R12: Word write even: hold byte, no strobe
// R13: Word write odd: latch high, held low
// R14: Word write: high strobe, both selects
// R15: Byte select: both halves, LSb selects byte
// R16: Memory wires byte address or selects
// R17: Byte/word write memories ignore byte address
// R18: 8-bit width is multiplexed on low bits
// R19: 8-bit fetch reads two bytes per cycle
// R20: 8-bit memory uses byte address line
// R21: 8-bit table write: both halves, LSb address
// R22: Write mode field decodes three configurations
// R23: Disable bit is bit 7, resets to 0
// R24: Wait field adds three-minus-code cycles
// R25: Sleep freezes pins, selects held high
// R26: Holding latch kept until odd write
// R27: Ownership changes on cycle boundaries
`timescale 1ns/100ps
`include "emb_params.svh"
module emb_bus_ctrl
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  clkEn,
  // Straps and power state
  input  wire emb_pkg::emb_mode_type memMode,
  input  wire emb_pkg::emb_aw_type   addrWidth,
  input  wire logic                  dataWidth16,
  input  wire logic                  sleepIdle,
  // Core side
  input  wire emb_pkg::emb_req_type  coreReq,
  input  wire logic                  execInternal,
  output logic                       coreStall,
  output logic [15:0]                fetchData,
  output logic                       fetchValid,
  // Memory side
  input  wire logic [15:0]           adIn,
  output emb_pkg::emb_pins_type      busPins,
  output logic                       busOwnsPins,
  // AXI4-Lite slave
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  logic [7:0]  bus_control_reg_ff;
  logic [7:0]  holdLatch_ff;
  logic        ownBus_ff;
  logic        disPend_ff;
  logic [1:0]  phase_ff;
  logic [3:0]  waitCnt_ff;
  logic [3:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        awHave_ff;
  logic        wHave_ff;
  emb_pkg::emb_pins_type pins_ff;
  emb_pkg::emb_pins_type nxt_pins;
  logic        ext;
  logic        extMode;
  logic        ext_bus_disable_bit;
  logic [1:0]  write_mode_select;
  logic [1:0]  waitCode;
  logic        boundary;
  logic        nxt_own;
  logic        ptrLsb;

  // Extra table wait cycles for a wait code
  function automatic logic [1:0] waitCycles(input logic [1:0] code);
    waitCycles = 2'h3 - code;  // R24
  endfunction : waitCycles

  // Mask of address/data lines tied to the configured width
  function automatic logic [15:0] adMask(input emb_pkg::emb_aw_type aw);
    adMask = (aw == emb_pkg::EMB_AW_12) ? 16'h0fff : 16'hffff;  // R7
  endfunction : adMask

  assign extMode             = (memMode == emb_pkg::EMB_MODE_EXTENDED);
  assign ext_bus_disable_bit = bus_control_reg_ff[`EMB_DIS_BIT];
  assign write_mode_select   = bus_control_reg_ff[`EMB_WM_HI:`EMB_WM_LO];
  assign waitCode            = bus_control_reg_ff[`EMB_WAIT_HI:`EMB_WAIT_LO];
  assign ext      = extMode & ~sleepIdle & (coreReq.fetch | coreReq.tblRead | coreReq.tblWrite);
  assign boundary = (phase_ff == `EMB_QCOUNT) & (waitCnt_ff == 4'h0);  // R27
  assign ptrLsb   = coreReq.addr[0];

  // Ownership next value: external access wins, disable only when internal
  always_comb
  begin
    if (!extMode)
      nxt_own = 1'b0;  // R1
    else if (ext)
      nxt_own = 1'b1;  // R2 R4
    else if (ext_bus_disable_bit && (disPend_ff || !execInternal))
      nxt_own = ownBus_ff;  // R5
    else
      nxt_own = ~ext_bus_disable_bit;  // R3
  end

  // Pin ownership moves only at instruction cycle ends
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      ownBus_ff <= 1'b0;
    else if (clkEn && boundary && !sleepIdle)
      ownBus_ff <= nxt_own;  // R27
  end

  // Disable set from external code waits until internal execution
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      disPend_ff <= 1'b0;
    else if (clkEn)
    begin
      if (!extMode || !ext_bus_disable_bit || execInternal)
        disPend_ff <= 1'b0;  // R5
      else if (!execInternal && ownBus_ff && boundary)
        disPend_ff <= 1'b1;  // R5
    end
  end

  // Four-phase instruction cycle; table waits stretch the last phase
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      phase_ff   <= 2'h0;
      waitCnt_ff <= 4'h0;
    end
    else if (clkEn && !sleepIdle)
    begin
      if (phase_ff == `EMB_QCOUNT && waitCnt_ff != 4'h0)
        waitCnt_ff <= waitCnt_ff - 4'h1;  // R24
      else
      begin
        phase_ff <= phase_ff + 2'h1;
        if (phase_ff == 2'h2 && (coreReq.tblRead || coreReq.tblWrite) && ext)
          waitCnt_ff <= {waitCycles(waitCode), 2'b00};  // R24 four clocks per wait
      end
    end
  end

  // Core stalls through wait states and the active cycle
  assign coreStall = ext & ~boundary;

  // Word write holding latch, kept until an odd write uses it
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      holdLatch_ff <= 8'h00;
    else if (clkEn && ext && coreReq.tblWrite && dataWidth16 && write_mode_select[1]
             && !ptrLsb && phase_ff == 2'h0)
      holdLatch_ff <= coreReq.tableLatch;  // R12 R26
  end

  // Pin pattern for the current phase
  always_comb
  begin
    nxt_pins                = pins_ff;
    if (!sleepIdle)
    begin
      nxt_pins.adOe           = 16'h0000;  // R6
      nxt_pins.aHighOe        = 1'b0;
      nxt_pins.chipSel_n      = 1'b1;  // R6
      nxt_pins.readStb_n      = 1'b1;
      nxt_pins.wrStbHigh_n    = 1'b1;
      nxt_pins.wrStbLow_n     = 1'b1;
      nxt_pins.upperByteSel_n = 1'b1;
      nxt_pins.lowerByteSel_n = 1'b1;
      nxt_pins.addrLatch      = 1'b0;
      nxt_pins.byteAddrLsb    = 1'b0;
      nxt_pins.aHigh          = coreReq.addr[19:16];
      if (ext)
      begin
        nxt_pins.adOe      = adMask(addrWidth);  // R2 R4 R7 R8
        nxt_pins.aHighOe   = (addrWidth == emb_pkg::EMB_AW_20);  // R7
        nxt_pins.chipSel_n = 1'b0;  // R10
        unique case (phase_ff)
          2'h0:
          begin
            nxt_pins.adOut     = coreReq.addr[16:1];
            nxt_pins.addrLatch = 1'b1;  // R9
            if (!dataWidth16)
              nxt_pins.adOut = coreReq.addr[15:0];  // R18
          end
          2'h1:
          begin
            nxt_pins.adOut = coreReq.addr[16:1];
          end
          default:
          begin
            if (coreReq.tblWrite)
            begin
              nxt_pins.adOut       = {coreReq.tableLatch, coreReq.tableLatch};  // R11 R15 R21
              nxt_pins.byteAddrLsb = ptrLsb;  // R14 R21
              if (!dataWidth16)
                nxt_pins.wrStbHigh_n = 1'b0;  // R21
              else if (write_mode_select[1])
              begin
                nxt_pins.upperByteSel_n = 1'b0;  // R14
                nxt_pins.lowerByteSel_n = 1'b0;
                if (ptrLsb)
                begin
                  nxt_pins.adOut       = {coreReq.tableLatch, holdLatch_ff};  // R13
                  nxt_pins.wrStbHigh_n = 1'b0;  // R14
                end
                else
                  nxt_pins.adOe = 16'h0000;  // R12
              end
              else if (write_mode_select == `EMB_WM_BYTESEL)
              begin
                nxt_pins.wrStbHigh_n    = 1'b0;  // R15
                nxt_pins.upperByteSel_n = ~ptrLsb;
                nxt_pins.lowerByteSel_n = ptrLsb;
              end
              else
              begin
                nxt_pins.wrStbHigh_n = ~ptrLsb;  // R11
                nxt_pins.wrStbLow_n  = ptrLsb;
              end
            end
            else
            begin
              nxt_pins.adOe      = 16'h0000;
              nxt_pins.readStb_n = 1'b0;  // R9 R19
              nxt_pins.upperByteSel_n = 1'b0;
              nxt_pins.lowerByteSel_n = 1'b0;
              if (!dataWidth16)
                nxt_pins.byteAddrLsb = (phase_ff == `EMB_QCOUNT);  // R19
            end
          end
        endcase
      end
    end
    else
    begin
      nxt_pins.chipSel_n      = 1'b1;  // R10 R25
      nxt_pins.upperByteSel_n = 1'b1;
      nxt_pins.lowerByteSel_n = 1'b1;
    end
  end

  // Registered pins; sleep keeps the rest frozen
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pins_ff                <= '0;
      pins_ff.chipSel_n      <= 1'b1;
      pins_ff.readStb_n      <= 1'b1;
      pins_ff.wrStbHigh_n    <= 1'b1;
      pins_ff.wrStbLow_n     <= 1'b1;
      pins_ff.upperByteSel_n <= 1'b1;
      pins_ff.lowerByteSel_n <= 1'b1;
    end
    else if (clkEn)
      pins_ff <= nxt_pins;  // R25
  end

  assign busPins     = pins_ff;
  assign busOwnsPins = ownBus_ff | ext;  // R4 R8

  // Read data capture: 16-bit word at once, or two 8-bit halves
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      fetchData  <= 16'h0000;
      fetchValid <= 1'b0;
    end
    else if (clkEn)
    begin
      fetchValid <= 1'b0;
      if (!pins_ff.readStb_n)
      begin
        if (dataWidth16)
          fetchData <= adIn;  // R9
        else if (pins_ff.byteAddrLsb)
          fetchData[15:8] <= adIn[7:0];  // R19
        else
          fetchData[7:0] <= adIn[7:0];
        fetchValid <= dataWidth16 ? boundary : (pins_ff.byteAddrLsb && phase_ff == 2'h0);
      end
    end
  end

  // AXI write channels taken in either order
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      awHave_ff <= 1'b0;
      wHave_ff  <= 1'b0;
      awAddr_ff <= 4'h0;
      wData_ff  <= 32'h0;
      wStrb_ff  <= 4'h0;
    end
    else if (clkEn)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        awHave_ff <= 1'b0;
        wHave_ff  <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~awHave_ff;
  assign s_axi_wready  = ~wHave_ff;
  assign s_axi_bvalid  = awHave_ff & wHave_ff;
  assign s_axi_bresp   = (awAddr_ff == `EMB_ADDR_CTRL) ? `EMB_RESP_OKAY : `EMB_RESP_SLVERR;

  // Control register; locked in on-chip mode
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      bus_control_reg_ff <= `EMB_CTRL_RST;  // R23
    else if (clkEn && s_axi_bvalid && s_axi_bready && awAddr_ff == `EMB_ADDR_CTRL
             && wStrb_ff[0] && extMode)  // R1
      bus_control_reg_ff <= wData_ff[7:0] & `EMB_CTRL_MASK;  // R22 R23
  end

  // AXI read: one cycle after the address is taken
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end
    else if (clkEn)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `EMB_RESP_OKAY;
        unique case (s_axi_araddr)
          `EMB_ADDR_CTRL:   s_axi_rdata <= {24'h0, bus_control_reg_ff};
          `EMB_ADDR_STATUS: s_axi_rdata <= {28'h0, disPend_ff, ownBus_ff, phase_ff};
          `EMB_ADDR_HOLD:   s_axi_rdata <= {24'h0, holdLatch_ff};
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `EMB_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

endmodule : emb_bus_ctrl
